// ---- logic/timer8_counter_compare_unit.sv ----
// 8-bit timer/counter with two compare units and APB registers
`timescale 1ns/1ps
module timer8_counter_compare_unit
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register bus
    input wire timer8_pkg::apb_req_type apb_req,
    output timer8_pkg::apb_rsp_type apb_rsp,
    // tick sources, same clock domain
    input wire logic [6:0] tick_sources,
    // port pins
    input wire logic [1:0] port_data,
    input wire logic [1:0] output_pin_direction_bit,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    // interrupt
    output logic [2:0] irq
);
    typedef enum logic [1:0] {idle_st = 2'b00, access_st = 2'b01} bus_type;

    bus_type bus_state;
    logic [7:0] timer_control_a;
    logic [7:0] timer_control_b;
    logic [7:0] counter_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] buffer_a;
    logic [7:0] buffer_b;
    logic [2:0] timer_interrupt_mask;
    logic [2:0] timer_interrupt_flags;
    logic count_down;
    logic write_block;
    logic [1:0] compare_output_latch;
    logic [31:0] rdata;

    // decode
    wire [11:0] addr = apb_req.paddr;
    wire setup = apb_req.psel && !apb_req.penable;
    wire acc = apb_req.psel && apb_req.penable;
    wire wr = acc && apb_req.pwrite;
    wire [7:0] wd = apb_req.pwdata[7:0];
    wire mapped = addr == timer8_pkg::addr_control_a
        || addr == timer8_pkg::addr_control_b
        || addr == timer8_pkg::addr_counter
        || addr == timer8_pkg::addr_compare_a
        || addr == timer8_pkg::addr_compare_b
        || addr == timer8_pkg::addr_int_mask
        || addr == timer8_pkg::addr_int_flags
        || addr == timer8_pkg::addr_tick_src
        || addr == timer8_pkg::addr_int_ack;
    wire wr_ctl_a = wr && addr == timer8_pkg::addr_control_a;
    wire wr_ctl_b = wr && addr == timer8_pkg::addr_control_b;
    wire wr_cnt = wr && addr == timer8_pkg::addr_counter;
    wire wr_cmp_a = wr && addr == timer8_pkg::addr_compare_a;
    wire wr_cmp_b = wr && addr == timer8_pkg::addr_compare_b;
    wire wr_mask = wr && addr == timer8_pkg::addr_int_mask;
    wire wr_flags = wr && addr == timer8_pkg::addr_int_flags;
    wire wr_ack = wr && addr == timer8_pkg::addr_int_ack;

    // mode and clock
    wire [2:0] clock_select_field = timer_control_b[2:0];
    wire waveform_mode_bit2 = timer_control_b[timer8_pkg::wgm2_pos];
    wire waveform_mode_bit1 = timer_control_a[1];
    wire waveform_mode_bit0 = timer_control_a[0];
    wire [2:0] waveform_mode_field =
        {waveform_mode_bit2, waveform_mode_bit1, waveform_mode_bit0};
    wire [1:0] compare_output_mode_a =
        timer_control_a[timer8_pkg::com_a_pos +: 2];
    wire [1:0] compare_output_mode_b =
        timer_control_a[timer8_pkg::com_b_pos +: 2];
    // sources 1..7 selected by index; zero means stopped
    wire [7:0] src_vec = {tick_sources, 1'b0};
    wire timer_tick = src_vec[clock_select_field];

    wire mode_normal = waveform_mode_field == timer8_pkg::wgm_normal;
    wire mode_ctc = waveform_mode_field == timer8_pkg::wgm_ctc;
    wire mode_phase = waveform_mode_field == timer8_pkg::wgm_phase
        || waveform_mode_field == timer8_pkg::wgm_phase_top;
    wire mode_fast = waveform_mode_field == timer8_pkg::wgm_fast
        || waveform_mode_field == timer8_pkg::wgm_fast_top;
    wire mode_pwm = mode_phase || mode_fast;
    wire buffered = mode_pwm;
    // top is compare a in mode 2 and modes 4 to 7, max otherwise
    wire top_from_a = mode_ctc || waveform_mode_bit2;
    wire [7:0] top_value =
        top_from_a ? compare_value_a : timer8_pkg::max_value;
    wire at_top = counter_value == top_value;
    wire at_bottom = counter_value == timer8_pkg::bottom_value;

    // next counter value
    logic [7:0] next_counter;
    logic next_down;
    always_comb
    begin
        next_counter = counter_value;
        next_down = count_down;
        if (mode_phase)
        begin
            if (at_top)
                next_down = 1'b1;
            else if (at_bottom)
                next_down = 1'b0;
            next_counter = (at_top || (count_down && !at_bottom))
                ? counter_value - 8'h01 : counter_value + 8'h01;
        end
        else if ((mode_ctc || mode_fast) && at_top)
            next_counter = timer8_pkg::bottom_value;
        else
            next_counter = counter_value + 8'h01;
    end

    // comparators and blocking
    wire match_a = counter_value == compare_value_a;
    wire match_b = counter_value == compare_value_b;
    wire hit_a = timer_tick && match_a && !write_block;
    wire hit_b = timer_tick && match_b && !write_block;
    wire ovf_event = timer_tick && !wr_cnt && (mode_phase
        ? (at_bottom && count_down) : mode_fast ? at_top
        : (counter_value == timer8_pkg::max_value
        && (mode_normal || mode_ctc)));
    // buffer transfer at top (fast) or bottom/top (phase)
    wire reload = timer_tick && buffered
        && (mode_fast ? at_top : (at_top || at_bottom));

    // force strobes only in non-pwm modes
    wire force_a = wr_ctl_b && wd[timer8_pkg::force_a_pos]
        && !mode_pwm;
    wire force_b = wr_ctl_b && wd[timer8_pkg::force_b_pos]
        && !mode_pwm;

    function automatic logic latch_next(input logic cur, input logic [1:0] com,
        input logic pwm, input logic fast, input logic down, input logic hit,
        input logic frc, input logic bot, input logic top);
        logic v;
        v = cur;
        if (com != timer8_pkg::com_off)
        begin
            if (!pwm)
            begin
                if (hit || frc)
                    v = com == timer8_pkg::com_toggle ? !cur
                        : com == timer8_pkg::com_set;
            end
            else if (com == timer8_pkg::com_toggle)
            begin
                if (hit)
                    v = !cur;
            end
            else if (fast)
            begin
                if (hit)
                    v = com == timer8_pkg::com_set;
                else if (top)
                    v = com == timer8_pkg::com_clear;
            end
            else if (hit)
                v = (com == timer8_pkg::com_set) ^ down;
        end
        return v;
    endfunction

    wire [1:0] next_latch = {
        latch_next(compare_output_latch[1], compare_output_mode_b, mode_pwm,
            mode_fast, count_down, hit_b, force_b, at_bottom,
            timer_tick && at_top),
        latch_next(compare_output_latch[0], compare_output_mode_a, mode_pwm,
            mode_fast, count_down, hit_a, force_a, at_bottom,
            timer_tick && at_top)};

    wire [2:0] set_flags = {hit_b, hit_a, ovf_event};
    wire [2:0] clr_flags = (wr_flags ? wd[2:0] : 3'h0)
        | (wr_ack ? wd[2:0] : 3'h0);
    wire [2:0] next_flags =
        (timer_interrupt_flags & ~clr_flags) | set_flags;

    always_comb
    begin
        case (addr)
            timer8_pkg::addr_control_a: rdata = {24'h0, timer_control_a};
            timer8_pkg::addr_control_b:
                rdata = {24'h0, 2'h0, timer_control_b[5:0]};
            timer8_pkg::addr_counter: rdata = {24'h0, counter_value};
            timer8_pkg::addr_compare_a:
                rdata = {24'h0, buffered ? buffer_a : compare_value_a};
            timer8_pkg::addr_compare_b:
                rdata = {24'h0, buffered ? buffer_b : compare_value_b};
            timer8_pkg::addr_int_mask: rdata = {29'h0, timer_interrupt_mask};
            timer8_pkg::addr_int_flags:
                rdata = {29'h0, timer_interrupt_flags};
            default: rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bus_state <= idle_st;
            apb_rsp <= '0;
        end
        else
        begin
            case (bus_state)
                idle_st:
                    if (setup)
                    begin
                        bus_state <= access_st;
                        apb_rsp.pready <= 1'b1;
                        apb_rsp.pslverr <= !mapped;
                        apb_rsp.prdata <= rdata;
                    end
                access_st:
                begin
                    bus_state <= idle_st;
                    apb_rsp <= '0;
                end
                default: bus_state <= idle_st;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            timer_control_a <= timer8_pkg::reset_byte;
            timer_control_b <= timer8_pkg::reset_byte;
            timer_interrupt_mask <= 3'h0;
        end
        else
        begin
            if (wr_ctl_a)
                timer_control_a <= wd;
            if (wr_ctl_b)
                timer_control_b <= {2'h0, wd[5:0]};
            if (wr_mask)
                timer_interrupt_mask <= wd[2:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            counter_value <= timer8_pkg::reset_byte;
            count_down <= 1'b0;
            write_block <= 1'b0;
        end
        else
        begin
            if (wr_cnt)
                counter_value <= wd;
            else if (timer_tick)
            begin
                counter_value <= next_counter;
                count_down <= next_down;
            end
            // a counter write blocks matches until the next tick passes
            if (wr_cnt)
                write_block <= 1'b1;
            else if (timer_tick)
                write_block <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            compare_value_a <= timer8_pkg::reset_byte;
            compare_value_b <= timer8_pkg::reset_byte;
            buffer_a <= timer8_pkg::reset_byte;
            buffer_b <= timer8_pkg::reset_byte;
        end
        else
        begin
            if (wr_cmp_a)
                buffer_a <= wd;
            if (wr_cmp_b)
                buffer_b <= wd;
            if (wr_cmp_a && !buffered)
                compare_value_a <= wd;
            else if (reload)
                compare_value_a <= buffer_a;
            if (wr_cmp_b && !buffered)
                compare_value_b <= wd;
            else if (reload)
                compare_value_b <= buffer_b;
        end
    end

    // latch is not touched by mode writes, only by match, force or top in fast pwm
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            compare_output_latch <= 2'b00;
            timer_interrupt_flags <= 3'h0;
            pin_out <= 2'b00;
            pin_oe <= 2'b00;
            irq <= 3'h0;
        end
        else
        begin
            compare_output_latch <= next_latch;
            timer_interrupt_flags <= next_flags;
            pin_out[0] <= compare_output_mode_a != timer8_pkg::com_off
                ? next_latch[0] : port_data[0];
            pin_out[1] <= compare_output_mode_b != timer8_pkg::com_off
                ? next_latch[1] : port_data[1];
            pin_oe <= output_pin_direction_bit;
            irq <= next_flags & timer_interrupt_mask;
        end
    end

    property p_stopped;
        @(posedge clk) disable iff (!rst_b)
        (clock_select_field == timer8_pkg::cs_stopped && !wr_cnt)
            |=> $stable(counter_value);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("counter moved while stopped");

    property p_write_wins;
        @(posedge clk) disable iff (!rst_b)
        wr_cnt |=> counter_value == $past(wd);
    endproperty
    a_write_wins: assert property (p_write_wins)
        else $error("counter write lost");

    property p_normal_up;
        @(posedge clk) disable iff (!rst_b)
        (mode_normal && timer_tick && !wr_cnt)
            |=> counter_value == $past(counter_value) + 8'h01;
    endproperty
    a_normal_up: assert property (p_normal_up)
        else $error("normal mode did not increment");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_b)
        hit_a |=> timer_interrupt_flags[timer8_pkg::flag_a_pos];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("match flag a not set");

    property p_block;
        @(posedge clk) disable iff (!rst_b)
        (write_block && timer_tick && timer_interrupt_flags[2:1] == 2'b00)
            |=> timer_interrupt_flags[2:1] == 2'b00;
    endproperty
    a_block: assert property (p_block)
        else $error("match not blocked after counter write");

    property p_ovf_normal;
        @(posedge clk) disable iff (!rst_b)
        (mode_normal && timer_tick && !wr_cnt
            && counter_value == timer8_pkg::max_value)
            |=> counter_value == timer8_pkg::bottom_value
            && timer_interrupt_flags[timer8_pkg::flag_ovf_pos];
    endproperty
    a_ovf_normal: assert property (p_ovf_normal)
        else $error("overflow flag missing at wrap");

    property p_pwm_no_force;
        @(posedge clk) disable iff (!rst_b)
        (mode_pwm && wr_ctl_b && !hit_a && !(timer_tick && at_top))
            |=> compare_output_latch[0] == $past(compare_output_latch[0]);
    endproperty
    a_pwm_no_force: assert property (p_pwm_no_force)
        else $error("force changed latch in pwm mode");

    property p_com_off;
        @(posedge clk) disable iff (!rst_b)
        (compare_output_mode_a == timer8_pkg::com_off)
            |=> $stable(compare_output_latch[0]);
    endproperty
    a_com_off: assert property (p_com_off)
        else $error("latch changed with output mode off");

    property p_irq;
        @(posedge clk) disable iff (!rst_b)
        timer_interrupt_flags[1] && timer_interrupt_mask[1] && !wr_ack
            && !wr_flags |=> irq[1];
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled flag raised no interrupt");

    c_match_a: cover property (@(posedge clk) hit_a);
    c_ovf: cover property (@(posedge clk) ovf_event);
    c_force: cover property (@(posedge clk) force_a);
    c_reload: cover property (@(posedge clk) reload);
endmodule

// ---- logic/timer8_pkg.sv ----
// package: register map, field layout and modes of the 8-bit timer
// Function
// - clock select zero produces no tick; counter holds.
// - each tick clears, increments or decrements the counter per mode.
// - software reads and writes the counter at any time.
// - software counter write beats any clear or count that cycle.
// - mode field: two low bits in control A, high bit in control B.
// - per unit 8-bit comparator asserts match while counter equals compare.
// - match sets its flag on the following tick.
// - enabled flag requests interrupt; service acknowledge clears it.
// - writing one to a flag bit clears that flag.
// - compare values buffered in PWM modes, direct in normal and clear modes.
// - buffer moves to active compare only at top or bottom.
// - software compare access targets buffer when buffered, else active.
// - force strobe in non-PWM updates latch by output mode, no flag.
// - counter write blocks all matches on the next tick.
// - output mode unbuffered; new setting acts on next match.
// - reset clears each compare output latch.
// - nonzero output mode puts latch on pin; direction stays with port.
// - output mode zero leaves the latch unchanged on match.
// - output mode picks set/clear/toggle or PWM polarity, not counting.
// - mode zero counts up only and wraps ff to 00.
// - normal mode sets overflow when counter becomes zero; never clears it.
// - latches keep their values across mode changes.
// - bottom is 00, max ff, top is max or compare A per mode.
// - each source masked individually; all flags read in one register.
package timer8_pkg;
    localparam logic [11:0] addr_control_a = 12'h000;
    localparam logic [11:0] addr_control_b = 12'h004;
    localparam logic [11:0] addr_counter = 12'h008;
    localparam logic [11:0] addr_compare_a = 12'h00c;
    localparam logic [11:0] addr_compare_b = 12'h010;
    localparam logic [11:0] addr_int_mask = 12'h014;
    localparam logic [11:0] addr_int_flags = 12'h018;
    localparam logic [11:0] addr_tick_src = 12'h01c;
    localparam logic [11:0] addr_int_ack = 12'h020;
    // control a: [7:6] mode a, [5:4] mode b, [1:0] waveform low bits
    localparam int com_a_pos = 6;
    localparam int com_b_pos = 4;
    // control b: [7] force a, [6] force b, [3] waveform bit2, [2:0] clock sel
    localparam int force_a_pos = 7;
    localparam int force_b_pos = 6;
    localparam int wgm2_pos = 3;
    // flags and mask: [2] match b, [1] match a, [0] overflow
    localparam int flag_ovf_pos = 0;
    localparam int flag_a_pos = 1;
    localparam int flag_b_pos = 2;
    localparam logic [7:0] bottom_value = 8'h00;
    localparam logic [7:0] max_value = 8'hff;
    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic [2:0] cs_stopped = 3'h0;
    localparam logic [2:0] wgm_normal = 3'h0;
    localparam logic [2:0] wgm_phase = 3'h1;
    localparam logic [2:0] wgm_ctc = 3'h2;
    localparam logic [2:0] wgm_fast = 3'h3;
    localparam logic [2:0] wgm_phase_top = 3'h5;
    localparam logic [2:0] wgm_fast_top = 3'h7;
    localparam logic [1:0] com_off = 2'h0;
    localparam logic [1:0] com_toggle = 2'h1;
    localparam logic [1:0] com_clear = 2'h2;
    localparam logic [1:0] com_set = 2'h3;
    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_type;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_type;
endpackage

// ---- verif/timer8_counter_compare_unit_tb_top.sv ----
// self-checking testbench for the 8-bit timer/counter with compare units
`timescale 1ns/1ps
module timer8_counter_compare_unit_tb_top;
    logic clk;
    logic rst_b;
    timer8_pkg::apb_req_type req;
    timer8_pkg::apb_rsp_type rsp;
    logic [6:0] tick_sources;
    logic [1:0] port_data;
    logic [1:0] dir;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [2:0] irq;
    logic [31:0] q;
    logic e;
    int bad_count;
    int checks_done;

    timer8_counter_compare_unit i_dut
    (
        .clk(clk),
        .rst_b(rst_b),
        .apb_req(req),
        .apb_rsp(rsp),
        .tick_sources(tick_sources),
        .port_data(port_data),
        .output_pin_direction_bit(dir),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .irq(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] x,
        input logic [31:0] got);
        checks_done++;
        if (got !== x)
        begin
            $display("mismatch %s expected %h seen %h", nm, x, got);
            bad_count++;
        end
    endtask

    // reads right after the edge see the pre-edge (sampled) values
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            chk("pready", 32'h1, 32'h0);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h000000, d});
    endtask

    task automatic rdc(input logic [11:0] a, input logic [7:0] x,
        input string nm);
        bus(1'b0, a, 32'h00000000);
        chk(nm, {24'h000000, x}, q);
    endtask

    task automatic tick(input int n, input logic [6:0] m);
        repeat (n)
        begin
            @(posedge clk);
            tick_sources <= m;
            @(posedge clk);
            tick_sources <= 7'h00;
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic t_reset();
        for (int k = 0; k < 7; k++)
            rdc(12'(4 * k), 8'h00, "reset reg");
        chk("reset pin", 32'h0, {30'h0, pin_out});
        chk("reset irq", 32'h0, {29'h0, irq});
    endtask

    task automatic t_stopped();
        wr(timer8_pkg::addr_counter, 8'h42);
        tick(3, 7'h7f);
        rdc(timer8_pkg::addr_counter, 8'h42, "stopped cnt");
    endtask

    task automatic t_normal();
        wr(timer8_pkg::addr_compare_a, 8'h80);
        wr(timer8_pkg::addr_compare_b, 8'h90);
        wr(timer8_pkg::addr_counter, 8'hfd);
        wr(timer8_pkg::addr_control_b, 8'h01);
        tick(2, 7'h01);
        rdc(timer8_pkg::addr_counter, 8'hff, "count up");
        rdc(timer8_pkg::addr_int_flags, 8'h00, "no ovf");
        tick(1, 7'h01);
        rdc(timer8_pkg::addr_counter, 8'h00, "wrap");
        rdc(timer8_pkg::addr_int_flags, 8'h01, "ovf set");
        tick(1, 7'h01);
        rdc(timer8_pkg::addr_int_flags, 8'h01, "ovf kept");
        wr(timer8_pkg::addr_int_flags, 8'h01);
        rdc(timer8_pkg::addr_int_flags, 8'h00, "ovf w1c");
    endtask

    task automatic t_match();
        wr(timer8_pkg::addr_int_mask, 8'h02);
        wr(timer8_pkg::addr_compare_a, 8'h05);
        wr(timer8_pkg::addr_counter, 8'h03);
        tick(2, 7'h01);
        rdc(timer8_pkg::addr_int_flags, 8'h00, "pre match");
        tick(1, 7'h01);
        rdc(timer8_pkg::addr_int_flags, 8'h02, "match a");
        settle();
        chk("irq a", 32'h2, {29'h0, irq});
        wr(timer8_pkg::addr_int_ack, 8'h02);
        rdc(timer8_pkg::addr_int_flags, 8'h00, "serviced");
        settle();
        chk("irq off", 32'h0, {29'h0, irq});
    endtask

    // write while stopped must still mask the match of the first tick
    task automatic t_block();
        wr(timer8_pkg::addr_control_b, 8'h00);
        wr(timer8_pkg::addr_counter, 8'h05);
        wr(timer8_pkg::addr_control_b, 8'h01);
        tick(1, 7'h01);
        rdc(timer8_pkg::addr_int_flags, 8'h00, "blocked");
        rdc(timer8_pkg::addr_counter, 8'h06, "after block");
    endtask

    task automatic t_ctc();
        wr(timer8_pkg::addr_control_b, 8'h00);
        wr(timer8_pkg::addr_control_a, {5'h00, timer8_pkg::wgm_ctc});
        rdc(timer8_pkg::addr_control_a, 8'h02, "mode low");
        wr(timer8_pkg::addr_compare_a, 8'h03);
        wr(timer8_pkg::addr_counter, 8'h00);
        wr(timer8_pkg::addr_control_b, 8'h01);
        tick(4, 7'h01);
        rdc(timer8_pkg::addr_counter, 8'h00, "ctc clear");
        wr(timer8_pkg::addr_control_b, 8'h00);
        wr(timer8_pkg::addr_int_flags, 8'h07);
    endtask

    task automatic t_force();
        logic [1:0] cm [4];
        logic [3:0] ex;
        cm = '{timer8_pkg::com_clear, timer8_pkg::com_set,
            timer8_pkg::com_toggle, timer8_pkg::com_toggle};
        ex = 4'b1010;
        for (int k = 0; k < 4; k++)
        begin
            wr(timer8_pkg::addr_control_a, {cm[k], timer8_pkg::com_set,
                4'h0});
            wr(timer8_pkg::addr_control_b, 8'hc0);
            settle();
            chk("force a", {31'h0, ex[k]}, {31'h0, pin_out[0]});
            chk("force b", 32'h1, {31'h0, pin_out[1]});
        end
        rdc(timer8_pkg::addr_int_flags, 8'h00, "force no flag");
        rdc(timer8_pkg::addr_control_b, 8'h00, "strobe reads 0");
        wr(timer8_pkg::addr_control_a, {timer8_pkg::com_clear, 4'h0,
            timer8_pkg::wgm_fast[1:0]});
        wr(timer8_pkg::addr_control_b, 8'h80);
        settle();
        chk("pwm force", 32'h1, {31'h0, pin_out[0]});
        wr(timer8_pkg::addr_control_a, 8'h00);
        port_data <= 2'b10;
        dir <= 2'b01;
        settle();
        chk("port data", 32'h2, {30'h0, pin_out});
        chk("direction", 32'h1, {30'h0, pin_oe});
    endtask

    task automatic t_buffer();
        wr(timer8_pkg::addr_control_a, {6'h00, timer8_pkg::wgm_fast[1:0]});
        wr(timer8_pkg::addr_compare_b, 8'h20);
        rdc(timer8_pkg::addr_compare_b, 8'h20, "buffer");
        wr(timer8_pkg::addr_control_a, 8'h00);
        rdc(timer8_pkg::addr_compare_b, 8'h90, "active kept");
        wr(timer8_pkg::addr_control_a, {6'h00, timer8_pkg::wgm_fast[1:0]});
        wr(timer8_pkg::addr_counter, 8'hfe);
        wr(timer8_pkg::addr_control_b, 8'h01);
        tick(2, 7'h01);
        wr(timer8_pkg::addr_control_b, 8'h00);
        wr(timer8_pkg::addr_control_a, 8'h00);
        rdc(timer8_pkg::addr_compare_b, 8'h20, "reload top");
    endtask

    task automatic t_phase();
        wr(timer8_pkg::addr_control_a, {6'h00, timer8_pkg::wgm_phase[1:0]});
        wr(timer8_pkg::addr_compare_b, 8'h40);
        wr(timer8_pkg::addr_counter, 8'hfe);
        wr(timer8_pkg::addr_control_b, 8'h01);
        tick(3, 7'h01);
        wr(timer8_pkg::addr_control_b, 8'h00);
        rdc(timer8_pkg::addr_counter, 8'hfd, "count down");
        wr(timer8_pkg::addr_control_a, 8'h00);
        rdc(timer8_pkg::addr_compare_b, 8'h40, "reload phase");
    endtask

    task automatic t_bus();
        rdc(12'h024, 8'h00, "unmapped");
        chk("slverr", 32'h1, {31'h0, e});
        rdc(timer8_pkg::addr_tick_src, 8'h00, "reserved");
        chk("no slverr", 32'h0, {31'h0, e});
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial
    begin
        bad_count = 0;
        checks_done = 0;
        rst_b = 1'b0;
        req = '0;
        tick_sources = 7'h00;
        port_data = 2'b00;
        dir = 2'b00;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_stopped();
        t_normal();
        t_match();
        t_block();
        t_ctc();
        t_force();
        t_buffer();
        t_phase();
        t_bus();
        end_sim();
    end
endmodule
